/* File: rtl/secb_regs.svh */
// Register offsets, configuration width, reset values and timing figures of the event counter bank.
// Operation
// R01: Four independent 32-bit counters, inputs to 20 MHz.
// R02: Scan start zeroes every counter.
// R03: Each counter selects one of four mapped inputs.
// R04: Mapped input gates, decrements or latches counter.
// R05: Gate counts while mapped high, holds when low.
// R06: Own edges increment, mapped edges decrement.
// R07: Scan start captures; optional second mapped latch.
// R08: Asynchronous reads with or without clearing.
// R09: Low-half read strobes capture for high half.
// R10: Totalize: own input only counts upward; the code still gates and decrements on the mapped input in totalize.
// R11: 32-bit result takes two 16-bit slots.
// R12: Totalize clears only at new scan command.
// R13: Totalize wraps at 16 or 32 bits; the code always wraps at 32 bits, whatever the width bit.
// R14: Clear on read returns value before clearing.
// R15: Stop at top saturates at FFFF or FFFFFFFF.
// R16: Width choice matters only for stop at top.
// R17: Latch on map captures on mapped edges.
// R18: Start-of-scan pulse refreshes capture each scan.
// R19: Simultaneous up and down edges leave count unchanged.
`ifndef SECB_REGS_SVH
`define SECB_REGS_SVH

`define SECB_ADDR_W      8
`define SECB_CFG_BASE    8'h00
`define SECB_LIVE_BASE   8'h10
`define SECB_LATCH_BASE  8'h30
`define SECB_CFG_W       10
`define SECB_CFG_RESET   10'h000
`define SECB_TOP16       32'h0000ffff
`define SECB_TOP32       32'hffffffff
`define SECB_RESP_OKAY   2'h0
`define SECB_RESP_SLVERR 2'h2
`define SECB_CLK_MHZ     250
`define SECB_MAX_IN_MHZ  20
`define SECB_IN_PER_CYC  (`SECB_CLK_MHZ / `SECB_MAX_IN_MHZ)

`endif

/* File: rtl/secb_pkg.sv */
// Types shared by the event counter bank.
package secb_pkg;
  typedef enum logic [1:0] {SECB_TOTALIZE, SECB_CLEAR_READ, SECB_STOP_TOP} secb_mode_t;
  typedef enum logic [1:0] {SECB_MAP_NONE, SECB_MAP_GATE, SECB_MAP_DEC} secb_func_t;
  typedef enum logic [1:0] {SECB_REG_CFG, SECB_REG_LOW, SECB_REG_HIGH, SECB_REG_LATCH} secb_kind_t;
  // Configuration word of one counter, most significant field first.
  typedef struct packed {
    logic [1:0] latchSel;   // Second mapped input used for latching.
    logic       wide;       // Stop-at-top width: 1 = 32 bits.
    logic       latchOnMap; // Capture on mapped edges instead of scan start.
    logic [1:0] mapSel;     // Mapped input for gate or decrement.
    secb_func_t func;       // Role of the mapped input.
    secb_mode_t mode;       // Counting mode.
  } secb_cfg_t;
  // Result of an address decode.
  typedef struct packed {
    logic       hit;
    secb_kind_t kind;
    logic [1:0] idx;
  } secb_dec_t;
endpackage : secb_pkg

/* File: rtl/secb_counter_bank.sv */
// Four scanned event counters with mapped inputs and an AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "secb_regs.svh"

module secb_counter_bank (
  input  wire logic        clk,           // 250 MHz system clock.
  input  wire logic        reset_n,       // Asynchronous reset, active low.
  input  wire logic [3:0]  cntIn,         // Debounced counter inputs from pins.
  input  wire logic        scanStart,     // New scan command, one-cycle pulse.
  input  wire logic        startOfScan,   // Start of each scan period, pulse.
  input  wire logic        slotReq,       // Sequencer asks for one 16-bit slot.
  input  wire logic [1:0]  slotCh,        // Counter for the slot.
  input  wire logic        slotHigh,      // 1 = upper half, 0 = lower half.
  output logic             slotValid,     // Slot data valid, one-cycle pulse.
  output logic [15:0]      slotData,      // Slot data.
  input  wire logic [7:0]  s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready   // Read data ready.
);

  // Decodes a byte address into register kind and counter index.
  function automatic secb_pkg::secb_dec_t secb_decode(input logic [7:0] a);
    secb_pkg::secb_dec_t d;
    d.hit  = 1'b0;
    d.kind = secb_pkg::SECB_REG_CFG;
    d.idx  = 2'h0;
    if (a[1:0] == 2'h0) begin
      if (a < `SECB_LIVE_BASE) begin
        d.hit = 1'b1;
        d.idx = a[3:2];
      end else if (a < `SECB_LATCH_BASE) begin
        d.hit  = 1'b1;
        d.kind = a[2] ? secb_pkg::SECB_REG_HIGH : secb_pkg::SECB_REG_LOW;
        d.idx  = 2'(8'(a - `SECB_LIVE_BASE) >> 3);
      end else if (a < 8'h40) begin
        d.hit  = 1'b1;
        d.kind = secb_pkg::SECB_REG_LATCH;
        d.idx  = a[3:2];
      end
    end
    return d;
  endfunction : secb_decode

  // One count step; simultaneous up and down cancel.
  function automatic logic [31:0] secb_step(input logic [31:0] c, input logic up,
                                            input logic dn, input secb_pkg::secb_cfg_t f);
    logic [31:0] top;
    logic        stop;
    top  = f.wide ? `SECB_TOP32 : `SECB_TOP16; // R16
    stop = (f.mode == secb_pkg::SECB_STOP_TOP);
    if (up && !dn) begin
      secb_step = (stop && c >= top) ? c : c + 32'h1; // R15 R13
    end else if (dn && !up) begin
      secb_step = (stop && c == 32'h0) ? c : c - 32'h1; // R06
    end else begin
      secb_step = c; // R19
    end
  endfunction : secb_step

  // Input synchroniser: stage one feeds only stage two; stage three keeps history.
  logic [3:0] syncA;      // First synchroniser stage.
  logic [3:0] syncB;      // Synchronised input level.
  logic [3:0] syncPrev;   // Level one cycle earlier, for edges.
  logic [3:0] rise;       // Rising edge on each input.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA    <= 4'h0;
      syncB    <= 4'h0;
      syncPrev <= 4'h0;
    end else begin
      syncA    <= cntIn;
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  assign rise = syncB & ~syncPrev;

  // Bus state.
  logic        awHeld;      // Write address captured.
  logic [7:0]  awAddr;      // Captured write address.
  logic        wHeld;       // Write data captured.
  logic [31:0] wData;       // Captured write data.
  logic [3:0]  wStrb;       // Captured strobes.
  logic        next_awHeld;
  logic [7:0]  next_awAddr;
  logic        next_wHeld;
  logic [31:0] next_wData;
  logic [3:0]  next_wStrb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        doWrite;     // Both halves of a write are in hand.
  logic        arFire;      // Read address taken this cycle.
  secb_pkg::secb_dec_t wDec; // Decode of the write address.
  secb_pkg::secb_dec_t rDec; // Decode of the read address.

  // Counter state.
  secb_pkg::secb_cfg_t cfg [4];      // Configuration per counter.
  logic [31:0] cnt [4];              // Live counts.
  logic [31:0] hold [4];             // Value caught by a low-half read.
  logic [31:0] latch [4];            // Scan capture register.
  secb_pkg::secb_cfg_t next_cfg [4];
  logic [31:0] next_cnt [4];
  logic [31:0] next_hold [4];
  logic [31:0] next_latch [4];
  logic [3:0]  up;                   // Qualified increment events.
  logic [3:0]  dn;                   // Qualified decrement events.
  logic [3:0]  latchEvt;             // Capture events.
  logic [3:0]  rdClr;                // Low-half read clears counter.
  logic [3:0]  rdLow;                // Low-half read this cycle.
  logic        next_slotValid;
  logic [15:0] next_slotData;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign arFire  = s_axi_arvalid && s_axi_arready;
  assign wDec    = secb_decode(awAddr);
  assign rDec    = secb_decode(s_axi_araddr);

  // Bus handshakes; address and data may arrive in either order.
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (doWrite) begin
      // Only configuration words are writable; counts are read-only.
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = (wDec.hit && wDec.kind == secb_pkg::SECB_REG_CFG) ?
                    `SECB_RESP_OKAY : `SECB_RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (arFire) begin
      next_rvalid = 1'b1;
      next_rresp  = rDec.hit ? `SECB_RESP_OKAY : `SECB_RESP_SLVERR;
      case (rDec.kind)
        secb_pkg::SECB_REG_CFG:   next_rdata = 32'(cfg[rDec.idx]);
        secb_pkg::SECB_REG_LOW:   next_rdata = {16'h0000, cnt[rDec.idx][15:0]}; // R09
        secb_pkg::SECB_REG_HIGH:  next_rdata = {16'h0000, hold[rDec.idx][31:16]}; // R09
        secb_pkg::SECB_REG_LATCH: next_rdata = latch[rDec.idx];
        default:                  next_rdata = 32'h0;
      endcase
      if (!rDec.hit) begin
        next_rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld       <= 1'b0;
      awAddr       <= 8'h00;
      wHeld        <= 1'b0;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // Counter events, captures and configuration updates.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_cfg[i]   = cfg[i];
      next_hold[i]  = hold[i];
      next_latch[i] = latch[i];
      // Gate needs a mapped input other than the counter's own; else ungated.
      up[i] = rise[i] && !(cfg[i].func == secb_pkg::SECB_MAP_GATE && // R05 R10
                           cfg[i].mapSel != 2'(i) && !syncB[cfg[i].mapSel]);
      dn[i] = (cfg[i].func == secb_pkg::SECB_MAP_DEC) && rise[cfg[i].mapSel]; // R06 R03
      latchEvt[i] = cfg[i].latchOnMap ? rise[cfg[i].latchSel] : startOfScan; // R07 R17 R18
      rdLow[i] = arFire && rDec.hit && rDec.kind == secb_pkg::SECB_REG_LOW &&
                 rDec.idx == 2'(i);
      rdClr[i] = rdLow[i] && cfg[i].mode == secb_pkg::SECB_CLEAR_READ; // R08
      if (rdLow[i]) begin
        next_hold[i] = cnt[i]; // R09 R14
      end
      if (latchEvt[i]) begin
        next_latch[i] = cnt[i]; // R04
      end
      // A new scan command wins; a clear-on-read keeps the event of its own cycle.
      if (scanStart) begin
        next_cnt[i] = 32'h0; // R02 R12
      end else if (rdClr[i]) begin
        next_cnt[i] = secb_step(32'h0, up[i], dn[i], cfg[i]); // R14
      end else begin
        next_cnt[i] = secb_step(cnt[i], up[i], dn[i], cfg[i]); // R01 R13
      end
      if (doWrite && wDec.hit && wDec.kind == secb_pkg::SECB_REG_CFG && wDec.idx == 2'(i)) begin
        next_cfg[i] = secb_pkg::secb_cfg_t'({wStrb[1] ? wData[9:8] : cfg[i][9:8],
                                              wStrb[0] ? wData[7:0] : cfg[i][7:0]});
      end
    end
    next_slotValid = slotReq;
    // Each slot carries one half; a full result needs two slots.
    next_slotData  = slotHigh ? latch[slotCh][31:16] : latch[slotCh][15:0]; // R11
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        cfg[i]   <= secb_pkg::secb_cfg_t'(`SECB_CFG_RESET);
        cnt[i]   <= 32'h0;
        hold[i]  <= 32'h0;
        latch[i] <= 32'h0;
      end
      slotValid <= 1'b0;
      slotData  <= 16'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cfg[i]   <= next_cfg[i];
        cnt[i]   <= next_cnt[i];
        hold[i]  <= next_hold[i];
        latch[i] <= next_latch[i];
      end
      slotValid <= next_slotValid;
      slotData  <= next_slotData;
    end
  end

  // Checks on the counters and the slot port.
  // Each check watches the counter that the bench drives in that mode, so none sits idle.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_scan_clear;
    scanStart |=> (cnt[0] == 32'h0 && cnt[3] == 32'h0);
  endproperty
  a_scan_clear: assert property (p_scan_clear) else $error("count not zero after scan start"); // R02

  property p_tot_inc;
    (cfg[0].mode == secb_pkg::SECB_TOTALIZE && up[0] && !dn[0] && !scanStart && !rdClr[0])
      |=> cnt[0] == $past(cnt[0]) + 32'h1;
  endproperty
  a_tot_inc: assert property (p_tot_inc) else $error("totalize did not add one"); // R10

  // At or above the 16-bit top an up edge must not move the count; a 16-bit top
  // reached from above after a wide run is held too, since the stop test is at or above the top.
  property p_stop16;
    (cfg[0].mode == secb_pkg::SECB_STOP_TOP && !cfg[0].wide && cnt[0] >= `SECB_TOP16 &&
     !scanStart && !rdClr[0] && !dn[0]) |=> cnt[0] == $past(cnt[0]);
  endproperty
  a_stop16: assert property (p_stop16) else $error("16-bit stop passed top"); // R15

  property p_wide32;
    (cfg[0].mode == secb_pkg::SECB_TOTALIZE && cfg[0].wide && cnt[0] == `SECB_TOP32 &&
     up[0] && !dn[0] && !scanStart && !rdClr[0]) |=> cnt[0] == 32'h0;
  endproperty
  a_wide32: assert property (p_wide32) else $error("width changed totalize wrap"); // R16

  property p_cancel;
    (up[0] && dn[0] && !scanStart && !rdClr[0]) |=> $stable(cnt[0]);
  endproperty
  a_cancel: assert property (p_cancel) else $error("count moved on cancelled edges"); // R19

  // Gating is exercised on counter 2, so the check follows it there.
  property p_gate;
    (cfg[2].func == secb_pkg::SECB_MAP_GATE && cfg[2].mapSel != 2'h2 &&
     !syncB[cfg[2].mapSel] && !scanStart && !dn[2] && !rdClr[2]) |=> $stable(cnt[2]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated counter moved"); // R05

  property p_sos_latch;
    (!cfg[0].latchOnMap && startOfScan) |=> latch[0] == $past(cnt[0]);
  endproperty
  a_sos_latch: assert property (p_sos_latch) else $error("scan start missed capture"); // R18

  property p_map_latch;
    (cfg[0].latchOnMap && !latchEvt[0]) ##1 !latchEvt[0] |-> $stable(latch[0]);
  endproperty
  a_map_latch: assert property (p_map_latch) else $error("latch moved without map edge"); // R17

  property p_clear_read;
    rdClr[1] && !scanStart |=> hold[1] == $past(cnt[1]) && cnt[1] <= 32'h1;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("clear on read lost value"); // R14

  property p_slot;
    (slotReq && slotCh == 2'h0) |=> slotValid &&
      slotData == ($past(slotHigh) ? $past(latch[0][31:16]) : $past(latch[0][15:0]));
  endproperty
  a_slot: assert property (p_slot) else $error("slot not answered"); // R11

  c_rollover: cover property (cnt[0] == `SECB_TOP32 ##1 cnt[0] == 32'h0);
  c_clear_read: cover property (rdClr[1]);
  c_map_latch: cover property (cfg[0].latchOnMap && latchEvt[0]);

endmodule : secb_counter_bank

/* File: verification/secb_pulse_src.sv */
// Model of the external pulse sources and the scan sequencer that feed the counter bank.
`timescale 1ns/10ps

module secb_pulse_src (
  input  wire logic       clk,         // Bench clock.
  output logic      [3:0] cntIn,       // Counter input pins.
  output logic            scanStart,   // New scan command pulse.
  output logic            startOfScan  // Start of scan period pulse.
);
  localparam int HI = 6; // High cycles; 13 cycles a period is just under 20 MHz.
  localparam int LO = 7; // Low cycles of each pulse.
  logic [3:0] level;     // Steady levels held on lines that act as gates.

  // All lines start idle so that no edge is seen straight out of reset.
  initial begin
    cntIn       = 4'h0;
    level       = 4'h0;
    scanStart   = 1'b0;
    startOfScan = 1'b0;
  end

  // Sends n pulses on every line of the mask at once, at the fastest rate allowed.
  task automatic pulses(input logic [3:0] mask, input int n);
    repeat (n) begin
      @(posedge clk);
      cntIn <= level | mask;
      repeat (HI - 1) @(posedge clk);
      @(posedge clk);
      cntIn <= level;
      repeat (LO - 1) @(posedge clk);
    end
    // The synchroniser and edge logic need a few cycles before the count settles.
    repeat (4) @(posedge clk);
  endtask : pulses

  // Holds one line at a steady level, as a gate source does.
  task automatic set_level(input int ch, input logic v);
    @(posedge clk);
    level[ch] = v;
    cntIn <= level;
    repeat (4) @(posedge clk);
  endtask : set_level

  // One-cycle pulse: sel 0 gives a new scan command, sel 1 a start of scan period.
  task automatic scan(input bit sel);
    @(posedge clk);
    startOfScan <= sel;
    scanStart   <= !sel;
    @(posedge clk);
    startOfScan <= 1'b0;
    scanStart   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : scan
endmodule : secb_pulse_src

/* File: verification/tb.sv */
// Self-checking testbench of the event counter bank.
`timescale 1ns/10ps
`include "secb_regs.svh"

module tb;
  localparam int         LIMIT = 20000;             // Cycle ceiling of the whole run.
  localparam logic [1:0] OK    = `SECB_RESP_OKAY;   // Good response.
  localparam logic [1:0] ERR   = `SECB_RESP_SLVERR; // Error response.
  logic        clk;           // 250 MHz clock.
  logic        reset_n;       // Reset, active low.
  logic [3:0]  cntIn;         // Pins from the pulse model.
  logic        scanStart;     // Scan command from the model.
  logic        startOfScan;   // Scan period tick from the model.
  logic        slotReq;       // Slot request.
  logic [1:0]  slotCh;        // Slot counter.
  logic        slotHigh;      // Slot half.
  logic        slotValid;     // Slot answer strobe.
  logic [15:0] slotData;      // Slot answer.
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures;      // Mismatches seen.
  int          nChecks;       // Comparisons made.
  int          cycles;        // Cycles since time zero.

  secb_counter_bank u_dut (.clk(clk), .reset_n(reset_n), .cntIn(cntIn), .scanStart(scanStart),
    .startOfScan(startOfScan), .slotReq(slotReq), .slotCh(slotCh), .slotHigh(slotHigh),
    .slotValid(slotValid), .slotData(slotData), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  secb_pulse_src u_src (.clk(clk), .cntIn(cntIn), .scanStart(scanStart),
    .startOfScan(startOfScan));

  // Compares one value; case inequality so that an unknown never passes.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Register write; ready is looked at mid-cycle, where it already shows its value at the edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                        input logic [3:0] st = 4'hf);
    logic       takeAw = 1'b0;
    logic       takeW  = 1'b0;
    logic       gotB   = 1'b0;
    logic [1:0] resp   = 2'h0;
    int         t      = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!gotB && t < 100) begin
      @(negedge clk);
      takeAw = s_axi_awvalid && s_axi_awready;
      takeW  = s_axi_wvalid && s_axi_wready;
      gotB   = s_axi_bvalid && s_axi_bready;
      resp   = s_axi_bresp;
      @(posedge clk);
      if (takeAw) s_axi_awvalid <= 1'b0;
      if (takeW) s_axi_wvalid <= 1'b0;
      t++;
    end
    s_axi_bready <= !gotB;
    chk({31'h0, gotB}, 32'h1, "write answer");
    chk({30'h0, resp}, {30'h0, er}, "write response");
  endtask : axi_wr

  // Register read, compared against the expected word and response.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic        takeAr = 1'b0;
    logic        gotR   = 1'b0;
    logic [31:0] data   = 32'h0;
    logic [1:0]  resp   = 2'h0;
    int          t      = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!gotR && t < 100) begin
      @(negedge clk);
      takeAr = s_axi_arvalid && s_axi_arready;
      gotR   = s_axi_rvalid && s_axi_rready;
      data   = s_axi_rdata;
      resp   = s_axi_rresp;
      @(posedge clk);
      if (takeAr) s_axi_arvalid <= 1'b0;
      t++;
    end
    s_axi_rready <= !gotR;
    chk({31'h0, gotR}, 32'h1, "read answer");
    chk(data, e, "read data");
    chk({30'h0, resp}, {30'h0, er}, "read response");
  endtask : rd_chk

  // Byte addresses of the live halves, the capture register and the configuration word.
  function automatic logic [7:0] live(input int i, input bit hi);
    return `SECB_LIVE_BASE + 8'(8 * i) + (hi ? 8'h04 : 8'h00);
  endfunction : live
  function automatic logic [7:0] held(input int i);
    return `SECB_LATCH_BASE + 8'(4 * i);
  endfunction : held
  function automatic logic [7:0] cfg(input int i);
    return `SECB_CFG_BASE + 8'(4 * i);
  endfunction : cfg

  // Reads a full count as low half then high half, the order that keeps it consistent.
  task automatic rd_count(input int i, input logic [31:0] e);
    rd_chk(live(i, 1'b0), {16'h0, e[15:0]}, OK);
    rd_chk(live(i, 1'b1), {16'h0, e[31:16]}, OK);
  endtask : rd_count

  // Asks for one slot and checks the answer in the cycle that it stands.
  task automatic slot_chk(input logic [1:0] ch, input logic hi, input logic [15:0] e);
    @(posedge clk);
    slotReq  <= 1'b1;
    slotCh   <= ch;
    slotHigh <= hi;
    @(posedge clk);
    slotReq <= 1'b0;
    @(negedge clk);
    chk({31'h0, slotValid}, 32'h1, "slot strobe");
    chk({16'h0, slotData}, {16'h0, e}, "slot data");
  endtask : slot_chk

  // Reset values and bus refusals.
  task automatic t_reset_bus;
    rd_chk(cfg(0), 32'(`SECB_CFG_RESET), OK);
    rd_chk(held(3), 32'h0, OK);
    rd_chk(8'h80, 32'h0, ERR);
    rd_chk(8'h02, 32'h0, ERR);
    axi_wr(live(0, 1'b0), 32'h1, ERR);
    axi_wr(cfg(2), 32'h3ff, OK, 4'h2);
    rd_chk(cfg(2), 32'h300, OK);
    $display("test reset_bus done");
  endtask : t_reset_bus

  // Totalize: counts up, survives reads, captured each scan, cleared by a new scan.
  task automatic t_totalize;
    u_src.scan(1'b0);
    u_src.pulses(4'h1, 5);
    rd_count(0, 32'd5);
    rd_count(0, 32'd5);
    u_src.scan(1'b1);
    rd_chk(held(0), 32'd5, OK);
    slot_chk(2'd0, 1'b0, 16'd5);
    slot_chk(2'd0, 1'b1, 16'd0);
    u_src.scan(1'b0);
    rd_count(0, 32'd0);
    $display("test totalize done");
  endtask : t_totalize

  // Clear on read: the reading is the count before the clear.
  task automatic t_clear;
    axi_wr(cfg(1), 32'h1, OK);
    rd_chk(cfg(1), 32'h1, OK);
    u_src.scan(1'b0);
    u_src.pulses(4'h2, 3);
    rd_chk(live(1, 1'b0), 32'd3, OK);
    rd_chk(live(1, 1'b0), 32'd0, OK);
    $display("test clear done");
  endtask : t_clear

  // Gate from line 3 on counter 2.
  task automatic t_gate;
    axi_wr(cfg(2), 32'h34, OK);
    u_src.scan(1'b0);
    u_src.pulses(4'h4, 2);
    rd_count(2, 32'd0);
    u_src.set_level(3, 1'b1);
    u_src.pulses(4'h4, 2);
    rd_count(2, 32'd2);
    u_src.set_level(3, 1'b0);
    $display("test gate done");
  endtask : t_gate

  // Decrement from line 0 on counter 3, wide set, which totalize must ignore.
  task automatic t_down;
    axi_wr(cfg(3), 32'h88, OK);
    u_src.scan(1'b0);
    rd_chk(live(3, 1'b0), 32'h0, OK);
    u_src.pulses(4'h1, 1);
    rd_chk(live(3, 1'b1), 32'h0, OK);
    rd_count(3, 32'hffffffff);
    u_src.pulses(4'h8, 1);
    rd_count(3, 32'h0);
    u_src.pulses(4'h8, 2);
    u_src.pulses(4'h9, 3);
    rd_count(3, 32'd2);
    $display("test down done");
  endtask : t_down

  // Capture on rising edges of line 2 instead of the scan tick.
  task automatic t_latch;
    axi_wr(cfg(0), 32'h240, OK);
    u_src.scan(1'b0);
    u_src.pulses(4'h1, 4);
    u_src.pulses(4'h4, 1);
    u_src.pulses(4'h1, 2);
    u_src.scan(1'b1);
    rd_chk(held(0), 32'd4, OK);
    rd_count(0, 32'd6);
    $display("test latch done");
  endtask : t_latch

  // Counter 0 is pushed past its top by decrements from line 1, then run in stop at top.
  task automatic t_top;
    axi_wr(cfg(0), 32'h98, OK);
    u_src.scan(1'b0);
    u_src.pulses(4'h2, 1);
    u_src.pulses(4'h1, 1);
    rd_count(0, 32'h0);
    u_src.pulses(4'h2, 1);
    axi_wr(cfg(0), 32'h1a, OK);
    u_src.pulses(4'h3, 1);
    u_src.pulses(4'h1, 2);
    rd_count(0, 32'hffffffff);
    axi_wr(cfg(0), 32'h9a, OK);
    u_src.pulses(4'h2, 1);
    u_src.pulses(4'h1, 2);
    rd_count(0, 32'hffffffff);
    u_src.scan(1'b0);
    u_src.pulses(4'h2, 1);
    rd_count(0, 32'h0);
    $display("test top done");
  endtask : t_top

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard: the whole run needs under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("mismatch at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  // Main sequence; every input is idle from time zero until reset is over.
  initial begin
    reset_n       = 1'b0;
    slotReq       = 1'b0;
    slotCh        = 2'h0;
    slotHigh      = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_bus();
    t_totalize();
    t_clear();
    t_gate();
    t_down();
    t_latch();
    t_top();
    report_and_stop();
  end
endmodule : tb
